// ==== verilog/bkf_pkg.sv ====
// constants, field positions and types of the backlight fault status register group
// assumes one 50 MHz clock shared by every module that imports it
package bkf_pkg;

	// register addresses
	localparam logic [7:0]  BKF_ADDR_FAULT    = 8'h02;
	localparam logic [7:0]  BKF_ADDR_IDENT    = 8'h03;
	localparam logic [7:0]  BKF_ADDR_DIRECT   = 8'h04;
	localparam logic [7:0]  BKF_ADDR_TEMP_HI  = 8'h05;

	// fault register field positions
	localparam int          BKF_OPEN_BIT      = 7;
	localparam int          BKF_SHORT_BIT     = 6;
	localparam int          BKF_MULTI_BIT     = 5;
	localparam int          BKF_SINGLE_BIT    = 4;
	localparam int          BKF_ANY_LED_BIT   = 3;
	localparam int          BKF_OVC_BIT       = 2;
	localparam int          BKF_TSD_BIT       = 1;
	localparam int          BKF_UV_BIT        = 0;

	// identification field positions
	localparam int          BKF_PANEL_BIT     = 7;
	localparam int          BKF_MAKER_LSB     = 3;

	// widths
	localparam int          BKF_LED_COUNT     = 6;
	localparam int          BKF_TEMP_W        = 11;
	localparam int          BKF_OCP_CNT_W     = 22;

	// reset values
	localparam logic [7:0]  BKF_FAULT_RESET   = 8'h00;
	localparam logic [5:0]  BKF_DIRECT_RESET  = 6'h00;
	localparam logic [10:0] BKF_TEMP_RESET    = 11'h000;
	localparam logic [7:0]  BKF_RDATA_RESET   = 8'h00;

	// identification codes, values arbitrary
	localparam logic        BKF_PANEL_CODE    = 1'h0;
	localparam logic [3:0]  BKF_MAKER_CODE    = 4'h5;
	localparam logic [2:0]  BKF_VERSION_CODE  = 3'h2;

	// timing
	localparam int          BKF_CLK_HZ        = 50_000_000;
	localparam int          BKF_OCP_TIME_MS   = 50;
	localparam int          BKF_OCP_CYCLES    = (BKF_CLK_HZ / 1000) * BKF_OCP_TIME_MS;

	typedef enum logic [1:0] {
		BKF_TS_RUN = 2'b01,
		BKF_TS_HOT = 2'b10
	} bkf_therm_type;

endpackage : bkf_pkg

// ==== verilog/bkf_ocp_if.sv ====
// carrier between the fault register group and its boost-low timer
// assumes both ends share SYS_CLK_I
`timescale 1ns/100ps
interface bkf_ocp_if;
	logic ce;
	logic boost_on;
	logic boost_low;
	logic expired;

	modport timer (input ce, input boost_on, input boost_low, output expired);
	modport owner (output ce, output boost_on, output boost_low, input expired);
endinterface : bkf_ocp_if

// ==== verilog/bkf_ocp_timer.sv ====
// boost-low duration timer for over-current detection
// assumes boost_low synchronous to the clock; count limit may be shortened for simulation
`timescale 1ns/100ps
module bkf_ocp_timer
	import bkf_pkg::*;
#(
	parameter int OCP_CYCLES = BKF_OCP_CYCLES
) (
	// clock and reset
	input  wire logic SYS_CLK_I,
	input  wire logic ARST_N_I,
	// carrier
	bkf_ocp_if.timer  ocp
);
	localparam logic [BKF_OCP_CNT_W-1:0] LIMIT = BKF_OCP_CNT_W'(OCP_CYCLES);

	logic [BKF_OCP_CNT_W-1:0] low_count;
	logic                     expired;

	// count continuous low time while the boost runs
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			low_count <= '0;
			expired   <= 1'b0;
		end else if (ocp.ce) begin
			if (!ocp.boost_on || !ocp.boost_low) begin
				low_count <= '0;
				expired   <= 1'b0;
			end else if (low_count != LIMIT) begin
				low_count <= low_count + 1'b1;
			end else begin
				expired   <= 1'b1;
			end
		end
	end

	assign ocp.expired = expired;

	low_restart_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		ocp.ce && !ocp.boost_low |=> !expired && low_count == '0)
		else $error("boost-low timer did not restart");

endmodule : bkf_ocp_timer

// ==== verilog/bkf_fault_regs.sv ====
// fault, identification, direct-output and temperature-high-byte registers
// assumes register strobes and pins synchronous to SYS_CLK_I, one access per strobe
// Operation
// - any open LED output sets the sticky open flag, fault bit 7
// - any shorted LED output sets the sticky short flag, fault bit 6
// - bit 5 set when two or more channels have faulted
// - bit 4 set when exactly one channel has faulted
// - bit 3 is the OR of all LED faults
// - boost low over 50 ms sets bit 2 and stops the boost
// - boost restarts by itself once the over-current flag clears
// - die at 150 C sets bit 1, stops boost and LED outputs
// - after thermal shutdown, outputs stay off until die cools to 130 C
// - input under-voltage sets bit 0, outputs off until input recovers
// - any set fault flag holds the open-drain fault pin low
// - reading address 02h or enable pin low clears flags, releases pin
// - direct bits 5:0 at 04h; zero leaves the output under PWM
// - reading the high temperature byte latches the full eleven-bit reading
`timescale 1ns/100ps
module bkf_fault_regs
	import bkf_pkg::*;
#(
	parameter int OCP_CYCLES = BKF_OCP_CYCLES
) (
	// clock, reset, enable
	input  wire logic                     SYS_CLK_I,
	input  wire logic                     ARST_N_I,
	input  wire logic                     CE_I,
	// register access
	input  wire logic [7:0]               REG_ADDR_I,
	input  wire logic                     REG_RD_I,
	input  wire logic                     REG_WR_I,
	input  wire logic [7:0]               REG_WDATA_I,
	output logic      [7:0]               REG_RDATA_O,
	// analog monitors
	input  wire logic [BKF_LED_COUNT-1:0] LED_OPEN_I,
	input  wire logic [BKF_LED_COUNT-1:0] LED_SHORT_I,
	input  wire logic                     BOOST_LOW_I,
	input  wire logic                     DIE_HOT_I,
	input  wire logic                     DIE_COOL_I,
	input  wire logic                     VIN_LOW_I,
	input  wire logic [BKF_TEMP_W-1:0]    TEMP_I,
	// enable pin and pwm
	input  wire logic                     ENABLE_I,
	input  wire logic [BKF_LED_COUNT-1:0] PWM_I,
	// outputs
	output logic                          FAULT_N_O,
	output logic                          FAULT_OE_O,
	output logic                          BOOST_EN_O,
	output logic      [BKF_LED_COUNT-1:0] LED_DRIVE_O,
	output logic      [2:0]               TEMP_LOW_O
);

	function automatic logic [2:0] count_ones(input logic [BKF_LED_COUNT-1:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < BKF_LED_COUNT; i++) begin
			n = n + {2'h0, v[i]};
		end
		return n;
	endfunction : count_ones

	logic                     open_flag;
	logic                     short_flag;
	logic [BKF_LED_COUNT-1:0] chan_flag;
	logic                     overcurrent_flag;
	logic                     thermal_shutdown_flag;
	logic                     undervoltage_flag;
	logic [5:0]               direct_sel;
	logic [BKF_TEMP_W-1:0]    temp_hold;
	bkf_therm_type            therm_state;
	bkf_therm_type            next_therm_state;
	logic [7:0]               fault_flags;
	logic [7:0]               next_fault_flags;
	logic [BKF_LED_COUNT-1:0] chan_fault;
	logic [BKF_LED_COUNT-1:0] next_chan_flag;
	logic                     clear_req;
	logic                     any_led_fault_flag;
	logic                     outputs_ok;
	logic                     boost_ok;
	logic [2:0]               chan_total;
	logic [7:0]               ident_word;

	bkf_ocp_if ocp ();

	bkf_ocp_timer #(
		.OCP_CYCLES (OCP_CYCLES)
	) u_ocp_timer (
		.SYS_CLK_I (SYS_CLK_I),
		.ARST_N_I  (ARST_N_I),
		.ocp       (ocp)
	);

	assign ocp.ce        = CE_I;
	assign ocp.boost_on  = BOOST_EN_O;
	assign ocp.boost_low = BOOST_LOW_I;

	assign chan_fault = LED_OPEN_I | LED_SHORT_I;
	assign clear_req  = (REG_RD_I && REG_ADDR_I == BKF_ADDR_FAULT) || !ENABLE_I;
	assign ident_word = {BKF_PANEL_CODE, BKF_MAKER_CODE, BKF_VERSION_CODE};

	// assembled fault register view
	always_comb begin
		chan_total         = count_ones(chan_flag);
		any_led_fault_flag = |chan_flag;
		fault_flags        = BKF_FAULT_RESET;
		fault_flags[BKF_OPEN_BIT]    = open_flag;
		fault_flags[BKF_SHORT_BIT]   = short_flag;
		fault_flags[BKF_MULTI_BIT]   = chan_total >= 3'h2;
		fault_flags[BKF_SINGLE_BIT]  = chan_total == 3'h1;
		fault_flags[BKF_ANY_LED_BIT] = any_led_fault_flag;
		fault_flags[BKF_OVC_BIT]     = overcurrent_flag;
		fault_flags[BKF_TSD_BIT]     = thermal_shutdown_flag;
		fault_flags[BKF_UV_BIT]      = undervoltage_flag;
	end

	// next state of the sticky flags; a set beats a clear in the same cycle
	always_comb begin
		next_chan_flag = (chan_flag & {BKF_LED_COUNT{!clear_req}}) | chan_fault;
		next_fault_flags = BKF_FAULT_RESET;
		next_fault_flags[BKF_OPEN_BIT]  = (open_flag && !clear_req) || |LED_OPEN_I;
		next_fault_flags[BKF_SHORT_BIT] = (short_flag && !clear_req) || |LED_SHORT_I;
		next_fault_flags[BKF_ANY_LED_BIT] = |next_chan_flag;
		next_fault_flags[BKF_OVC_BIT] = (overcurrent_flag && !clear_req) || ocp.expired;
		next_fault_flags[BKF_TSD_BIT] = (thermal_shutdown_flag && !clear_req) || DIE_HOT_I;
		next_fault_flags[BKF_UV_BIT]  = (undervoltage_flag && !clear_req) || VIN_LOW_I;
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			open_flag             <= 1'b0;
			short_flag            <= 1'b0;
			chan_flag             <= '0;
			overcurrent_flag      <= 1'b0;
			thermal_shutdown_flag <= 1'b0;
			undervoltage_flag     <= 1'b0;
		end else if (CE_I) begin
			open_flag             <= next_fault_flags[BKF_OPEN_BIT];
			short_flag            <= next_fault_flags[BKF_SHORT_BIT];
			chan_flag             <= next_chan_flag;
			overcurrent_flag      <= next_fault_flags[BKF_OVC_BIT];
			thermal_shutdown_flag <= next_fault_flags[BKF_TSD_BIT];
			undervoltage_flag     <= next_fault_flags[BKF_UV_BIT];
		end
	end

	// thermal shutdown hysteresis
	always_comb begin
		next_therm_state = therm_state;
		unique case (therm_state)
			BKF_TS_RUN: begin
				if (DIE_HOT_I) begin
					next_therm_state = BKF_TS_HOT;
				end
			end
			BKF_TS_HOT: begin
				if (DIE_COOL_I && !DIE_HOT_I) begin
					next_therm_state = BKF_TS_RUN;
				end
			end
			default: begin
				next_therm_state = BKF_TS_HOT;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			therm_state <= BKF_TS_RUN;
		end else if (CE_I) begin
			therm_state <= next_therm_state;
		end
	end

	assign outputs_ok = next_therm_state == BKF_TS_RUN && !VIN_LOW_I;
	assign boost_ok   = outputs_ok && !next_fault_flags[BKF_OVC_BIT];

	// fault pin, boost enable
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			FAULT_N_O  <= 1'b1;
			FAULT_OE_O <= 1'b0;
			BOOST_EN_O <= 1'b0;
		end else if (CE_I) begin
			FAULT_N_O  <= !(|next_fault_flags);
			FAULT_OE_O <= |next_fault_flags;
			BOOST_EN_O <= boost_ok;
		end
	end

	// per-output PWM or direct drive
	for (genvar g = 0; g < BKF_LED_COUNT; g++) begin : g_led
		always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
			if (!ARST_N_I) begin
				LED_DRIVE_O[g] <= 1'b0;
			end else if (CE_I) begin
				LED_DRIVE_O[g] <= outputs_ok && (direct_sel[g] || PWM_I[g]);
			end
		end
	end

	// direct control register
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			direct_sel <= BKF_DIRECT_RESET;
		end else if (CE_I && REG_WR_I && REG_ADDR_I == BKF_ADDR_DIRECT) begin
			direct_sel <= REG_WDATA_I[5:0];
		end
	end

	// temperature snapshot taken by the high-byte read
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			temp_hold <= BKF_TEMP_RESET;
		end else if (CE_I && REG_RD_I && REG_ADDR_I == BKF_ADDR_TEMP_HI) begin
			temp_hold <= TEMP_I;
		end
	end

	assign TEMP_LOW_O = temp_hold[2:0];

	// read data, one cycle after the strobe
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			REG_RDATA_O <= BKF_RDATA_RESET;
		end else if (CE_I && REG_RD_I) begin
			unique case (REG_ADDR_I)
				BKF_ADDR_FAULT:   REG_RDATA_O <= fault_flags;
				BKF_ADDR_IDENT:   REG_RDATA_O <= ident_word;
				BKF_ADDR_DIRECT:  REG_RDATA_O <= {2'h0, direct_sel};
				BKF_ADDR_TEMP_HI: REG_RDATA_O <= TEMP_I[10:3];
				default:          REG_RDATA_O <= BKF_RDATA_RESET;
			endcase
		end
	end

	open_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && |LED_OPEN_I |=> fault_flags[BKF_OPEN_BIT] && !FAULT_N_O)
		else $error("open fault not flagged");
	short_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && |LED_SHORT_I |=> fault_flags[BKF_SHORT_BIT] && FAULT_OE_O)
		else $error("short fault not flagged");
	multi_chan_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && count_ones(chan_fault) >= 3'h2 |=> fault_flags[BKF_MULTI_BIT]
		&& !fault_flags[BKF_SINGLE_BIT])
		else $error("multi-channel fault not flagged");
	single_chan_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && (chan_flag == '0 || clear_req) && count_ones(chan_fault) == 3'h1
		|=> fault_flags[BKF_SINGLE_BIT] && !fault_flags[BKF_MULTI_BIT])
		else $error("single-channel fault not flagged");
	any_led_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		fault_flags[BKF_ANY_LED_BIT] == (fault_flags[BKF_OPEN_BIT] || fault_flags[BKF_SHORT_BIT]))
		else $error("any-LED flag disagrees with open and short flags");
	ovc_stop_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && ocp.expired |=> overcurrent_flag && !BOOST_EN_O)
		else $error("over-current did not stop the boost");
	boost_restart_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && $fell(overcurrent_flag) && therm_state == BKF_TS_RUN && !$past(VIN_LOW_I)
		&& !DIE_HOT_I |-> BOOST_EN_O)
		else $error("boost did not restart after over-current clear");
	therm_stop_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && DIE_HOT_I |=> thermal_shutdown_flag && !BOOST_EN_O && LED_DRIVE_O == '0)
		else $error("thermal shutdown did not stop outputs");
	therm_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && therm_state == BKF_TS_HOT && !DIE_COOL_I |=> therm_state == BKF_TS_HOT
		&& LED_DRIVE_O == '0)
		else $error("outputs left shutdown before cooling");
	uv_stop_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && VIN_LOW_I |=> undervoltage_flag && !BOOST_EN_O && LED_DRIVE_O == '0)
		else $error("under-voltage did not stop outputs");
	pin_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && |fault_flags && !clear_req |=> FAULT_OE_O && !FAULT_N_O)
		else $error("fault pin released while a flag is set");
	flag_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && clear_req && chan_fault == '0 && !ocp.expired && !DIE_HOT_I && !VIN_LOW_I
		|=> fault_flags == BKF_FAULT_RESET && FAULT_N_O && !FAULT_OE_O)
		else $error("flags not cleared");
	direct_drive_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && outputs_ok |=> LED_DRIVE_O == ($past(direct_sel) | $past(PWM_I)))
		else $error("LED drive does not follow direct and PWM selection");
	temp_latch_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == BKF_ADDR_TEMP_HI
		|=> REG_RDATA_O == $past(TEMP_I[10:3]) && TEMP_LOW_O == $past(TEMP_I[2:0]))
		else $error("temperature not latched on high-byte read");
	ident_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == BKF_ADDR_IDENT |=> REG_RDATA_O == ident_word)
		else $error("identification read wrong");

endmodule : bkf_fault_regs

// ==== bench/bkf_host_model.sv ====
// host side of the register port, one access per task call
// assumes strobes are sampled on the rising edge of clk_i
`timescale 1ns/100ps
module bkf_host_model (
	// clock
	input  wire logic       clk_i,
	// register port
	output logic      [7:0] addr_o,
	output logic            rd_o,
	output logic            wr_o,
	output logic      [7:0] wdata_o,
	input  wire logic [7:0] rdata_i
);
	initial begin
		addr_o = 8'h00;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 8'h00;
	end

	// released lines show the inverse of the last value
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : reg_write

	// reading 02h is how the host clears flags; 05h is read before the low byte
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1 d = rdata_i;
	endtask : reg_read
endmodule : bkf_host_model

// ==== bench/tb_backlight_fault_status_regs.sv ====
// self-checking bench of the fault register group
// assumes the design's sticky flags and a shortened over-current count
`timescale 1ns/100ps
module tb_backlight_fault_status_regs;
	import bkf_pkg::*;
	localparam int          OCP = 8;
	localparam logic [10:0] T0  = 11'h5A3;

	logic       clk;
	logic       arst_n;
	logic       ce;
	logic       boost_low;
	logic       die_hot;
	logic       die_cool;
	logic       vin_low;
	logic       enable;
	logic [5:0] led_open;
	logic [5:0] led_short;
	logic [5:0] pwm;
	logic [10:0] temp;
	logic [7:0] addr;
	logic       rd;
	logic       wr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       fault_n;
	logic       fault_oe;
	logic       boost_en;
	logic [5:0] led_drive;
	logic [2:0] temp_low;
	int         err_total = 0;
	int         samples_checked = 0;
	// open-drain pin with pull-up
	wire        fault_line = fault_oe ? fault_n : 1'b1;

	logic [5:0] row_open  [4] = '{6'h04, 6'h00, 6'h01, 6'h03};
	logic [5:0] row_short [4] = '{6'h00, 6'h01, 6'h02, 6'h00};
	logic [7:0] row_exp   [4] = '{8'h98, 8'h58, 8'hE8, 8'hA8};

	bkf_fault_regs #(.OCP_CYCLES(OCP)) u_dut (
		.SYS_CLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce),
		.REG_ADDR_I(addr), .REG_RD_I(rd), .REG_WR_I(wr), .REG_WDATA_I(wdata),
		.REG_RDATA_O(rdata), .LED_OPEN_I(led_open), .LED_SHORT_I(led_short),
		.BOOST_LOW_I(boost_low), .DIE_HOT_I(die_hot), .DIE_COOL_I(die_cool),
		.VIN_LOW_I(vin_low), .TEMP_I(temp), .ENABLE_I(enable), .PWM_I(pwm),
		.FAULT_N_O(fault_n), .FAULT_OE_O(fault_oe), .BOOST_EN_O(boost_en),
		.LED_DRIVE_O(led_drive), .TEMP_LOW_O(temp_low)
	);

	bkf_host_model u_host (
		.clk_i(clk), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .rdata_i(rdata)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic finish_test;
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t byte got %h expected %h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_pin(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t pin got %b expected %b", $time, got, exp);
		end
	endtask : chk_pin

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_host.reg_read(a, d);
		chk_byte(d, exp);
	endtask : rd_chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// bounded wait for the boost enable to reach a level
	task automatic wait_boost(input logic exp);
		int i;
		for (i = 0; i < 40 && boost_en !== exp; i++) begin
			@(posedge clk);
			#1;
		end
		if (boost_en !== exp) begin
			err_total++;
			$display("BAD %0t boost enable wait ran out", $time);
			finish_test();
		end
	endtask : wait_boost

	initial begin
		arst_n = 1'b0;
		ce = 1'b1;
		boost_low = 1'b0;
		die_hot = 1'b0;
		die_cool = 1'b1;
		vin_low = 1'b0;
		enable = 1'b1;
		led_open = 6'h00;
		led_short = 6'h00;
		pwm = 6'h00;
		temp = 11'h000;
		cyc(2);
		chk_pin(fault_line, 1'b1);
		chk_pin(boost_en, 1'b0);
		chk_byte({2'b00, led_drive}, 8'h00);
		@(posedge clk);
		arst_n <= 1'b1;
		cyc(2);
		chk_pin(boost_en, 1'b1);
		rd_chk(BKF_ADDR_FAULT, BKF_FAULT_RESET);
		rd_chk(BKF_ADDR_DIRECT, 8'h00);
		rd_chk(BKF_ADDR_IDENT, {BKF_PANEL_CODE, BKF_MAKER_CODE, BKF_VERSION_CODE});
		rd_chk(BKF_ADDR_TEMP_HI, 8'h00);
		rd_chk(8'h10, 8'h00);
		foreach (row_exp[k]) begin
			@(posedge clk);
			led_open <= row_open[k];
			led_short <= row_short[k];
			@(posedge clk);
			led_open <= 6'h00;
			led_short <= 6'h00;
			cyc(1);
			chk_pin(fault_line, 1'b0);
			rd_chk(BKF_ADDR_FAULT, row_exp[k]);
			chk_pin(fault_line, 1'b1);
			rd_chk(BKF_ADDR_FAULT, 8'h00);
		end
		// direct control and refused accesses
		u_host.reg_write(BKF_ADDR_DIRECT, 8'hFF);
		rd_chk(BKF_ADDR_DIRECT, 8'h3F);
		chk_byte({2'b00, led_drive}, 8'h3F);
		pwm <= 6'h30;
		u_host.reg_write(BKF_ADDR_DIRECT, 8'h05);
		u_host.reg_write(BKF_ADDR_IDENT, 8'h00);
		rd_chk(BKF_ADDR_IDENT, {BKF_PANEL_CODE, BKF_MAKER_CODE, BKF_VERSION_CODE});
		chk_byte({2'b00, led_drive}, 8'h35);
		u_host.reg_write(BKF_ADDR_DIRECT, 8'h00);
		@(posedge clk);
		ce <= 1'b0;
		u_host.reg_write(BKF_ADDR_DIRECT, 8'h3F);
		ce <= 1'b1;
		rd_chk(BKF_ADDR_DIRECT, 8'h00);
		chk_byte({2'b00, led_drive}, 8'h30);
		// thermal shutdown with hysteresis
		@(posedge clk);
		die_cool <= 1'b0;
		die_hot <= 1'b1;
		@(posedge clk);
		die_hot <= 1'b0;
		cyc(1);
		chk_pin(boost_en, 1'b0);
		chk_byte({2'b00, led_drive}, 8'h00);
		cyc(4);
		chk_pin(boost_en, 1'b0);
		die_cool <= 1'b1;
		wait_boost(1'b1);
		rd_chk(BKF_ADDR_FAULT, 8'h02);
		// input under-voltage
		@(posedge clk);
		vin_low <= 1'b1;
		cyc(2);
		chk_pin(boost_en, 1'b0);
		chk_byte({2'b00, led_drive}, 8'h00);
		vin_low <= 1'b0;
		wait_boost(1'b1);
		rd_chk(BKF_ADDR_FAULT, 8'h01);
		// boost low for the scaled over-current time
		@(posedge clk);
		boost_low <= 1'b1;
		cyc(OCP);
		chk_pin(boost_en, 1'b1);
		wait_boost(1'b0);
		boost_low <= 1'b0;
		cyc(4);
		chk_pin(boost_en, 1'b0);
		rd_chk(BKF_ADDR_FAULT, 8'h04);
		wait_boost(1'b1);
		// enable pin low clears the flags
		@(posedge clk);
		led_short <= 6'h01;
		@(posedge clk);
		led_short <= 6'h00;
		enable <= 1'b0;
		cyc(2);
		enable <= 1'b1;
		cyc(1);
		chk_pin(fault_line, 1'b1);
		rd_chk(BKF_ADDR_FAULT, 8'h00);
		// high byte read latches the whole reading
		temp <= T0;
		cyc(1);
		rd_chk(BKF_ADDR_TEMP_HI, T0[10:3]);
		temp <= 11'h000;
		cyc(2);
		chk_byte({5'h00, temp_low}, {5'h00, T0[2:0]});
		// second reset with a pending fault
		u_host.reg_write(BKF_ADDR_DIRECT, 8'h15);
		led_open <= 6'h20;
		@(posedge clk);
		led_open <= 6'h00;
		arst_n <= 1'b0;
		cyc(2);
		chk_pin(fault_line, 1'b1);
		arst_n <= 1'b1;
		rd_chk(BKF_ADDR_FAULT, 8'h00);
		rd_chk(BKF_ADDR_DIRECT, 8'h00);
		finish_test();
	end
endmodule : tb_backlight_fault_status_regs
